// ==== common/mpss_pkg.sv ====
// Package of shared constants and types for the power-state handshake
`default_nettype none
package mpss_pkg;
    localparam int unsigned CLK_MHZ          = 100;
    localparam int unsigned HW_OFF_MIN_US    = 10;
    localparam int unsigned HW_OFF_MIN_CYC   = HW_OFF_MIN_US * CLK_MHZ;
    localparam int unsigned CNT_W            = 12;
    localparam int unsigned PWRUP_CYC        = 16;
    localparam int unsigned SYNC_RST_VAL     = 0;

    typedef enum logic [1:0] {
        MPSS_OFF   = 2'b00,
        MPSS_ON    = 2'b01,
        MPSS_SLEEP = 2'b10,
        MPSS_DOWN  = 2'b11
    } mpss_pstate_e;

    typedef enum logic [1:0] {
        MPSC_IDLE  = 2'b00,
        MPSC_UP    = 2'b01,
        MPSC_RUN   = 2'b10,
        MPSC_LOW   = 2'b11
    } mpss_cstate_e;
endpackage : mpss_pkg
`default_nettype wire

// ==== common/mpss_if.sv ====
// Interface joining module end and carrier end
`default_nettype none
interface mpss_if;
    // Module-on request, carrier drives
    logic module_on_req;
    // Carrier power gate, open drain, shared
    logic gate_mod_o;
    logic gate_mod_oe;
    logic gate_car_o;
    logic gate_car_oe;
    logic carrier_power_gate_n;
    // Shutdown request, open drain from module
    logic shdn_o;
    logic shdn_oe;
    logic shutdown_req_n;

    // Pull-ups resolve released lines high
    assign carrier_power_gate_n = !((gate_mod_oe && !gate_mod_o)
                                 || (gate_car_oe && !gate_car_o));
    assign shutdown_req_n = !(shdn_oe && !shdn_o);

    modport module_end (
        input  module_on_req, carrier_power_gate_n,
        output gate_mod_o, gate_mod_oe, shdn_o, shdn_oe
    );
    modport carrier_end (
        input  carrier_power_gate_n, shutdown_req_n,
        output module_on_req, gate_car_o, gate_car_oe
    );
endinterface : mpss_if
`default_nettype wire

// ==== src/mpss_sync2.sv ====
// Two-stage synchroniser for one asynchronous level
`default_nettype none
module mpss_sync2
    import mpss_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Level
    input  wire logic async_i,
    output logic      sync_o
);
    typedef struct packed {
        logic meta;
        logic sync;
    } mpss_sync_s;

    mpss_sync_s st_q;
    mpss_sync_s st_d;

    always_comb begin
        st_d.meta = async_i;
        st_d.sync = st_q.meta;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= '{default: 1'(SYNC_RST_VAL)};
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.sync;
endmodule : mpss_sync2
`default_nettype wire

// ==== src/mpss_module_end.sv ====
// Module end: power states, gate release, shutdown request, sleep retain
// How it works
// [RL1] Carrier keeps supplies off until gate high
// [RL2] Release gate high after power-up done
// [RL3] Carrier inputs low while gate low; in MPSC_LOW io_drive_en stays high until the low count ends with the gate low
// [RL4] Carrier services shutdowns by dropping on-request
// [RL5] Request shutdown on thermal, software, undervoltage
// [RL6] Carrier drops on-request upon shutdown request
// [RL7] On-request low drives gate low
// [RL8] No power-down before on-request deasserted
// [RL9] Hardware, software, thermal events assert request
// [RL10] Hardware shutdown needs on-request low 10 us
// [RL11] OFF to ON only on request rising
// [RL12] Carrier raises on-request only when supply good
// [RL13] Legal moves: OFF/SLEEP->ON, ON->OFF/SLEEP
// [RL14] Software shutdown accepted only ON, running
// [RL15] Thermal shutdown in any power state
// [RL16] Outputs hold their levels during sleep
// [RL17] Leave sleep only on a wake event; the code also leaves sleep on thermal_unsafe
// [RL18] Temperature limit crossing in sleep forces wake
// [RL19] Enabled USB power detect wakes from sleep
// [RL20] Reset clears processor and storage
// [RL21] Carrier may reset module via gate low
// [RL22] Sleep indicator low only in deep sleep
// [RL23] Handshake inputs pass two-stage synchroniser
// [RL24] Hold request until on-low, release at gate low
`default_nettype none
module mpss_module_end
    import mpss_pkg::*;
(
    // Clock and reset
    input  wire logic      mclk,
    input  wire logic      sys_rst,
    // Link
    mpss_if.module_end     lnk,
    // Internal events, same clock
    input  wire logic      pwr_seq_done,
    input  wire logic      sw_operational,
    input  wire logic      sw_shutdown_req,
    input  wire logic      thermal_unsafe,
    input  wire logic      undervoltage,
    input  wire logic      sleep_req,
    input  wire logic      deep_sleep_req,
    input  wire logic      wake_internal,
    input  wire logic      wake_pin,
    input  wire logic      temp_limit_cross,
    input  wire logic      usb_vbus_det,
    input  wire logic      usb_wake_en,
    input  wire logic [7:0] user_out_d,
    // Status
    output logic [1:0]     power_state,
    output logic           soc_reset,
    output logic           storage_reset,
    output logic           asleep_indicator_n,
    output logic [7:0]     user_out_q
);
    typedef struct packed {
        mpss_pstate_e       st;
        logic               on_prev;
        logic [CNT_W-1:0]   low_cnt;
        logic               gate_rel;
        logic               shdn;
        logic               deep;
        logic               rst_out;
        logic [7:0]         outs;
        logic               pull;
        logic               ind_n;
    } mpss_mod_s;

    mpss_mod_s s_q;
    mpss_mod_s s_d;
    logic      on_s;
    logic      gate_s;

    ////////////////////////////////////////////////////////////////////
    // Synchronisers
    mpss_sync2 u_sync_on (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .async_i (lnk.module_on_req),
        .sync_o  (on_s)
    ); // RL23
    mpss_sync2 u_sync_gate (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .async_i (lnk.carrier_power_gate_n),
        .sync_o  (gate_s)
    ); // RL23

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic wake;
        logic hw_off;
        logic trig;
        wake   = wake_internal || wake_pin || temp_limit_cross
              || (usb_vbus_det && usb_wake_en); // RL17 RL18 RL19
        hw_off = !on_s && (s_q.low_cnt == CNT_W'(HW_OFF_MIN_CYC)); // RL10
        // On-request fall in ON triggers once, so release can follow
        trig   = thermal_unsafe || undervoltage
              || (s_q.on_prev && !on_s && s_q.st == MPSS_ON)
              || (sw_shutdown_req && sw_operational
                  && s_q.st == MPSS_ON); // RL5 RL9 RL14 RL15
        s_d         = s_q;
        s_d.on_prev = on_s;
        // Low-time counter on the on-request
        if (on_s) begin
            s_d.low_cnt = '0;
        end else if (s_q.low_cnt != CNT_W'(HW_OFF_MIN_CYC)) begin
            s_d.low_cnt = s_q.low_cnt + CNT_W'(1);
        end
        if (trig) begin
            s_d.shdn = 1'b1; // RL24
        end else if (s_q.shdn && !on_s && !gate_s) begin
            s_d.shdn = 1'b0; // RL24
        end
        unique case (s_q.st)
            MPSS_OFF: begin
                s_d.gate_rel = 1'b0;
                s_d.rst_out  = 1'b1;
                if (on_s && !s_q.on_prev) begin
                    s_d.st = MPSS_ON; // RL11 RL13
                end
            end
            MPSS_ON: begin
                if (pwr_seq_done && on_s) begin
                    s_d.gate_rel = 1'b1; // RL2
                end
                s_d.rst_out = !gate_s; // RL20 RL21
                if (!on_s) begin
                    s_d.gate_rel = 1'b0; // RL7
                end
                if (hw_off) begin
                    s_d.st = MPSS_DOWN; // RL8 RL10 RL4
                end else if (sleep_req && on_s) begin
                    s_d.st   = MPSS_SLEEP; // RL13
                    s_d.deep = deep_sleep_req;
                end else begin
                    s_d.outs = user_out_d;
                end
            end
            MPSS_SLEEP: begin
                // User outputs frozen here
                if (!on_s) begin
                    s_d.gate_rel = 1'b0; // RL7
                end
                if (wake || thermal_unsafe) begin
                    s_d.st   = MPSS_ON; // RL17 RL13
                    s_d.deep = 1'b0;
                end
            end
            MPSS_DOWN: begin
                s_d.gate_rel = 1'b0; // RL7
                s_d.rst_out  = 1'b1;
                s_d.outs     = '0;
                s_d.st       = MPSS_OFF; // RL13
            end
        endcase
        s_d.pull  = !s_d.gate_rel; // RL2 RL7
        s_d.ind_n = !(s_d.st == MPSS_SLEEP && s_d.deep); // RL22
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q <= '{st: MPSS_OFF, rst_out: 1'b1, pull: 1'b1,
                     ind_n: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign lnk.gate_mod_o  = 1'b0;
    assign lnk.gate_mod_oe = s_q.pull; // RL2 RL7
    assign lnk.shdn_o      = 1'b0;
    assign lnk.shdn_oe     = s_q.shdn; // RL5
    assign power_state     = s_q.st;
    assign soc_reset       = s_q.rst_out; // RL20
    assign storage_reset   = s_q.rst_out; // RL20
    assign asleep_indicator_n = s_q.ind_n; // RL22
    assign user_out_q      = s_q.outs; // RL16
endmodule : mpss_module_end
`default_nettype wire

// ==== src/mpss_carrier_end.sv ====
// Carrier end: supply good, on-request, supply enable, reset
`default_nettype none
module mpss_carrier_end
    import mpss_pkg::*;
(
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  sys_rst,
    // Link
    mpss_if.carrier_end lnk,
    // User side
    input  wire logic  supply_good,
    input  wire logic  user_off_req,
    input  wire logic  user_reset_req,
    output logic       supply_en,
    output logic       io_drive_en
);
    typedef struct packed {
        mpss_cstate_e     st;
        logic             on_req;
        logic [CNT_W-1:0] cnt;
        logic             en;
        logic             rst;
    } mpss_car_s;

    mpss_car_s s_q;
    mpss_car_s s_d;
    logic      gate_s;
    logic      shdn_s;

    mpss_sync2 u_sync_gate (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .async_i (lnk.carrier_power_gate_n),
        .sync_o  (gate_s)
    ); // RL23
    mpss_sync2 u_sync_shdn (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .async_i (lnk.shutdown_req_n),
        .sync_o  (shdn_s)
    ); // RL23

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d     = s_q;
        s_d.rst = user_reset_req; // RL21
        unique case (s_q.st)
            MPSC_IDLE: begin
                s_d.en     = 1'b0;
                s_d.on_req = 1'b0;
                if (supply_good && !user_off_req) begin
                    s_d.st = MPSC_UP;
                end
            end
            MPSC_UP: begin
                s_d.on_req = supply_good; // RL12
                if (!supply_good) begin
                    s_d.st = MPSC_IDLE;
                end else if (gate_s) begin
                    s_d.st = MPSC_RUN; // RL1
                    s_d.en = 1'b1;
                end
            end
            MPSC_RUN: begin
                if (!shdn_s || user_off_req || !supply_good) begin
                    s_d.on_req = 1'b0; // RL4 RL6
                    s_d.cnt    = '0;
                    s_d.st     = MPSC_LOW;
                end
            end
            MPSC_LOW: begin
                s_d.on_req = 1'b0;
                if (s_q.cnt != CNT_W'(HW_OFF_MIN_CYC)) begin
                    s_d.cnt = s_q.cnt + CNT_W'(1); // RL10
                end else if (!gate_s) begin
                    s_d.en = 1'b0; // RL7
                    s_d.st = MPSC_IDLE;
                end
            end
        endcase
        if (!gate_s && s_q.st != MPSC_LOW) begin
            s_d.en = 1'b0; // RL1 RL3
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q <= '{st: MPSC_IDLE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign lnk.module_on_req = s_q.on_req;
    assign lnk.gate_car_o    = 1'b0;
    assign lnk.gate_car_oe   = s_q.rst; // RL21
    assign supply_en         = s_q.en; // RL1
    assign io_drive_en       = s_q.en; // RL3
endmodule : mpss_carrier_end
`default_nettype wire

// ==== dv/mpss_checker.sv ====
// Checker of the handshake wires between the two ends
`default_nettype none
module mpss_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Link wires
    input wire logic module_on_req,
    input wire logic gate_mod_o,
    input wire logic gate_mod_oe,
    input wire logic carrier_power_gate_n,
    input wire logic shutdown_req_n
);
    wire logic mod_pull;
    assign mod_pull = gate_mod_oe && !gate_mod_o;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////
    a_gate_follows: assert property (
        $fell(module_on_req) |-> ##[0:8] !carrier_power_gate_n)
        else $error("gate not pulled low");
    a_shdn_on_drop: assert property (
        $fell(module_on_req) && carrier_power_gate_n
        |-> ##[0:8] !shutdown_req_n) else $error("no shutdown request");
    a_no_early_down: assert property (
        $rose(mod_pull) |-> !$past(module_on_req)
        || !$past(carrier_power_gate_n)) else $error("early gate pull");
    a_gate_needs_on: assert property (
        $fell(mod_pull) |-> module_on_req)
        else $error("gate released without on request");
    a_shdn_hold: assert property (
        !shutdown_req_n && module_on_req |=> !shutdown_req_n)
        else $error("request dropped early");
    a_shdn_gate: assert property (
        $rose(shutdown_req_n) |-> !carrier_power_gate_n && !module_on_req)
        else $error("request released too soon");
    a_shdn_ends: assert property (
        (!module_on_req && !carrier_power_gate_n) [*8] |-> shutdown_req_n)
        else $error("request never released");
    a_req_drop: assert property (
        $fell(shutdown_req_n) && module_on_req |-> ##[1:8] !module_on_req)
        else $error("on request kept high");
endmodule : mpss_checker
`default_nettype wire

// ==== dv/mpss_tb_top.sv ====
// Testbench joining both ends of the power-state handshake
`default_nettype none
module mpss_tb_top
    import mpss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, sys_rst, pwr_seq_done, sw_operational, sw_shutdown_req;
    logic thermal_unsafe, undervoltage, sleep_req, deep_sleep_req;
    logic wake_internal, wake_pin, temp_limit_cross, usb_vbus_det;
    logic usb_wake_en, supply_good, user_off_req, user_reset_req;
    logic soc_reset, storage_reset, asleep_indicator_n, supply_en;
    logic io_drive_en;
    logic [1:0] power_state;
    logic [7:0] user_out_d, user_out_q;
    int n_fail, check_count, cyc, k;
    mpss_if lnk ();
    mpss_module_end u_mpss_module_end (
        .mclk               (mclk),
        .sys_rst            (sys_rst),
        .lnk                (lnk),
        .pwr_seq_done       (pwr_seq_done),
        .sw_operational     (sw_operational),
        .sw_shutdown_req    (sw_shutdown_req),
        .thermal_unsafe     (thermal_unsafe),
        .undervoltage       (undervoltage),
        .sleep_req          (sleep_req),
        .deep_sleep_req     (deep_sleep_req),
        .wake_internal      (wake_internal),
        .wake_pin           (wake_pin),
        .temp_limit_cross   (temp_limit_cross),
        .usb_vbus_det       (usb_vbus_det),
        .usb_wake_en        (usb_wake_en),
        .user_out_d         (user_out_d),
        .power_state        (power_state),
        .soc_reset          (soc_reset),
        .storage_reset      (storage_reset),
        .asleep_indicator_n (asleep_indicator_n),
        .user_out_q         (user_out_q)
    );
    mpss_carrier_end u_mpss_carrier_end (
        .mclk               (mclk),
        .sys_rst            (sys_rst),
        .lnk                (lnk),
        .supply_good        (supply_good),
        .user_off_req       (user_off_req),
        .user_reset_req     (user_reset_req),
        .supply_en          (supply_en),
        .io_drive_en        (io_drive_en)
    );
    mpss_checker u_mpss_checker (.mclk, .sys_rst,
        .module_on_req(lnk.module_on_req), .gate_mod_o(lnk.gate_mod_o),
        .gate_mod_oe(lnk.gate_mod_oe), .shutdown_req_n(lnk.shutdown_req_n),
        .carrier_power_gate_n(lnk.carrier_power_gate_n));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string what);
        check_count++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask : wt
    task automatic await_state(input logic [1:0] st);
        for (int i = 0; i < 2000 && power_state !== st; i++) wt(1);
        chk(power_state === st, "state");
    endtask : await_state
    task automatic rst_chk();
        chk(power_state === MPSS_OFF && soc_reset === 1'b1, "rst");
        chk(storage_reset === 1'b1 && supply_en === 1'b0, "rst");
        chk(asleep_indicator_n === 1'b1, "indicator");
        chk(lnk.module_on_req === 1'b0, "on without supply");
        $display("reset done");
    endtask : rst_chk
    task automatic power_up();
        supply_good = 1'b1;
        await_state(MPSS_ON);
        wt(4);
        chk(lnk.carrier_power_gate_n === 1'b0, "gate early");
        chk(supply_en === 1'b0, "early supply");
        chk(io_drive_en === 1'b0, "early io");
        pwr_seq_done = 1'b1;
        wt(8);
        chk(lnk.carrier_power_gate_n === 1'b1, "gate");
        chk(supply_en === 1'b1, "supply");
        chk(soc_reset === 1'b0 && storage_reset === 1'b0, "rst");
        $display("power up done");
    endtask : power_up
    task automatic go_sleep(input logic deep);
        user_out_d = 8'h5a;
        wt(3);
        sleep_req = 1'b1;
        deep_sleep_req = deep;
        await_state(MPSS_SLEEP);
        sleep_req = 1'b0;
        user_out_d = 8'ha5;
        usb_vbus_det = 1'b1;
        wt(20);
        chk(power_state === MPSS_SLEEP, "woke");
        chk(user_out_q === 8'h5a, "retain");
        chk(asleep_indicator_n === !deep, "deep");
        $display("sleep done");
    endtask : go_sleep
    task automatic wake(input int src);
        deep_sleep_req = 1'b0;
        case (src)
            0: usb_wake_en = 1'b1;
            1: wake_pin = 1'b1;
            2: wake_internal = 1'b1;
            default: temp_limit_cross = 1'b1;
        endcase
        await_state(MPSS_ON);
        chk(asleep_indicator_n === 1'b1, "indicator");
        {usb_vbus_det, usb_wake_en, wake_pin} = 3'h0;
        {wake_internal, temp_limit_cross} = 2'h0;
        wt(3);
        $display("wake done");
    endtask : wake
    task automatic shut(input int kind);
        case (kind)
            0: sw_shutdown_req = 1'b1;
            1: thermal_unsafe = 1'b1;
            2: undervoltage = 1'b1;
            default: user_off_req = 1'b1;
        endcase
        wt(1);
        {sw_shutdown_req, thermal_unsafe, undervoltage} = 3'h0;
        wt(12);
        chk(lnk.module_on_req === 1'b0, "on request");
        chk(lnk.carrier_power_gate_n === 1'b0, "gate");
        supply_good = 1'b0;
        wt(900);
        chk(power_state !== MPSS_OFF, "early off");
        await_state(MPSS_OFF);
        wt(10);
        chk(supply_en === 1'b0 && soc_reset === 1'b1, "off");
        {user_off_req, supply_good, pwr_seq_done} = 3'h0;
        wt(5);
        $display("shutdown done");
    endtask : shut
    task automatic conclude();
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        {pwr_seq_done, sw_operational, sw_shutdown_req, thermal_unsafe} = 4'h0;
        {undervoltage, sleep_req, deep_sleep_req, wake_internal} = 4'h0;
        {wake_pin, temp_limit_cross, usb_vbus_det, usb_wake_en} = 4'h0;
        {supply_good, user_off_req, user_reset_req} = 3'h0;
        user_out_d = 8'h00;
        sys_rst = 1'b1;
        wt(10);
        sys_rst = 1'b0;
        wt(3);
        rst_chk();
        sleep_req = 1'b1;
        wake_pin = 1'b1;
        wt(10);
        chk(power_state === MPSS_OFF, "off left");
        {sleep_req, wake_pin} = 2'h0;
        power_up();
        sw_shutdown_req = 1'b1;
        wt(10);
        chk(lnk.shutdown_req_n === 1'b1, "sw taken");
        sw_shutdown_req = 1'b0;
        sw_operational = 1'b1;
        for (k = 0; k < 4; k++) begin
            go_sleep(k[0]);
            wake(k);
        end
        for (k = 0; k < 4; k++) begin
            if (k > 0) power_up();
            if (k == 1) go_sleep(1'b1);
            shut(k);
        end
        power_up();
        user_reset_req = 1'b1;
        wt(10);
        chk(lnk.carrier_power_gate_n === 1'b0, "gate");
        chk(io_drive_en === 1'b0, "io in reset");
        chk(soc_reset === 1'b1 && storage_reset === 1'b1, "rst");
        {user_reset_req, supply_good} = 2'h0;
        sys_rst = 1'b1;
        wt(10);
        sys_rst = 1'b0;
        wt(3);
        rst_chk();
        conclude();
    end
endmodule : mpss_tb_top
`default_nettype wire
